// ===== core/lcc_pkg.sv
`default_nettype none
// ==========================================================
// Shared constants and types of the logic cell
package lcc_pkg;

  // ==========================================================
  // Register port widths
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;

  // ==========================================================
  // Register offsets
  localparam logic [ADDR_W-1:0] OFF_CELL_CONTROL = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_SIGNAL_POLARITY = 4'h1;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 4'h2;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 4'h3;

  // ==========================================================
  // Reset values
  localparam logic [DATA_W-1:0] RST_CELL_CONTROL = 8'h00;
  localparam logic [DATA_W-1:0] RST_SIGNAL_POLARITY = 8'h00;
  localparam logic [DATA_W-1:0] RST_IRQ_STATUS = 8'h00;
  localparam logic [DATA_W-1:0] RST_IRQ_MASK = 8'h00;

  // ==========================================================
  // Writable bits per register; others read as zero or live state
  localparam logic [DATA_W-1:0] WR_MASK_CELL_CONTROL = 8'hDF;
  localparam logic [DATA_W-1:0] WR_MASK_SIGNAL_POLARITY = 8'h8F;
  localparam logic [DATA_W-1:0] WR_MASK_IRQ = 8'h01;

  // ==========================================================
  // Logic function codes
  typedef enum logic [2:0] {
    FN_AND_OR   = 3'h0,
    FN_OR_XOR   = 3'h1,
    FN_AND4     = 3'h2,
    FN_SR_LATCH = 3'h3,
    FN_DFF_SR   = 3'h4,
    FN_DFF2_R   = 3'h5,
    FN_JK_R     = 3'h6,
    FN_LATCH_SR = 3'h7
  } lcc_fn_t;

  // ==========================================================
  // Register bus request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } lcc_bus_req_t;

  // Cell control register layout, bit 7 down to bit 0
  typedef struct packed {
    logic cell_enable;
    logic pin_output_enable;
    logic cell_output_status;
    logic rise_irq_enable;
    logic fall_irq_enable;
    lcc_fn_t function_select;
  } lcc_ctrl_t;

  // Signal polarity register layout, bit 7 down to bit 0
  typedef struct packed {
    logic output_invert;
    logic [2:0] unused;
    logic gate4_invert;
    logic gate3_invert;
    logic gate2_invert;
    logic gate1_invert;
  } lcc_pol_t;

endpackage
`default_nettype wire

// ===== core/lcc_logic_fn.sv
`default_nettype none
// ==========================================================
// Selectable logic function with its storage element
module lcc_logic_fn (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  input wire lcc_pkg::lcc_fn_t function_select,
  input wire logic [3:0] gate,
  output logic fn_out
);
  import lcc_pkg::*;

  logic g1_prev_q;
  logic out_q;
  logic out_d;
  logic clk_rise;

  // Gate 1 acts as the clock of the flip-flop functions
  assign clk_rise = gate[0] & ~g1_prev_q;

  // Previous gate 1 level for edge detection
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      g1_prev_q <= 1'b0;
    end else begin
      g1_prev_q <= gate[0];
    end
  end

  // Next output per function; reset input wins over set input, except in the SR latch where set wins
  always_comb begin
    out_d = out_q;
    case (function_select)
      FN_AND_OR: begin
        out_d = (gate[0] & gate[1]) | (gate[2] & gate[3]);
      end
      FN_OR_XOR: begin
        out_d = (gate[0] | gate[1]) ^ (gate[2] | gate[3]);
      end
      FN_AND4: begin
        out_d = &gate;
      end
      FN_SR_LATCH: begin
        if (gate[0] | gate[1]) begin
          out_d = 1'b1;
        end else if (gate[2] | gate[3]) begin
          out_d = 1'b0;
        end
      end
      FN_DFF_SR: begin
        if (gate[2]) begin
          out_d = 1'b0;
        end else if (gate[3]) begin
          out_d = 1'b1;
        end else if (clk_rise) begin
          out_d = gate[1];
        end
      end
      FN_DFF2_R: begin // [R1]
        if (gate[2]) begin
          out_d = 1'b0;
        end else if (clk_rise) begin
          out_d = gate[1] & gate[3];
        end
      end
      FN_JK_R: begin // [R1]
        if (gate[2]) begin
          out_d = 1'b0;
        end else if (clk_rise) begin
          case ({gate[1], gate[3]})
            2'b10: out_d = 1'b1;
            2'b01: out_d = 1'b0;
            2'b11: out_d = ~out_q;
            default: out_d = out_q;
          endcase
        end
      end
      FN_LATCH_SR: begin // [R1]
        if (gate[2]) begin
          out_d = 1'b0;
        end else if (gate[0]) begin
          out_d = 1'b1;
        end else if (!gate[3]) begin
          out_d = gate[1];
        end
      end
      default: begin
        out_d = 1'b0;
      end
    endcase
  end

  // Function output held cleared while the cell is off
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_q <= 1'b0;
    end else begin
      out_q <= run ? out_d : 1'b0; // [R8]
    end
  end

  assign fn_out = out_q;

endmodule
`default_nettype wire

// ===== core/lcc_top.sv
// Design decisions made here: the register addresses and the strobed register port.
`default_nettype none
// Function
// R1: Three-bit selector picks one of eight logic functions, including latch, JK, two-input DFF.
// R2: Output invert bit flips function result; status bit shows the inverted value.
// R3: Each gate invert bit flips that gate's output before the function.
// R4: Rising edge with rise enable, or falling edge with fall enable, sets flag.
// R5: Reset clears cell control; polarity and gating settings survive it.
// R6: Toggling output invert with edge interrupts enabled raises the interrupt.
// R7: Software clears the flag; an edge during the clear keeps it set.
// R8: Logic runs only when enabled; pin driven only when output enable set.
module lcc_top (
  input wire logic clk,
  input wire logic rstn,
  input wire logic por_n,
  input wire lcc_pkg::lcc_bus_req_t bus_req,
  output logic [lcc_pkg::DATA_W-1:0] rdata,
  input wire logic [3:0] gate_in,
  output logic cell_out,
  output logic pin_out,
  output logic pin_oe_n,
  output logic irq
);
  import lcc_pkg::*;

  // ==========================================================
  // Reset synchronisers
  logic rst_s1_q;
  logic rst_n_q;
  logic por_s1_q;
  logic por_n_q;

  // Release of the general reset
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  // Release of the power-on reset
  always_ff @(posedge clk or negedge por_n) begin
    if (!por_n) begin
      por_s1_q <= 1'b0;
      por_n_q <= 1'b0;
    end else begin
      por_s1_q <= 1'b1;
      por_n_q <= por_s1_q;
    end
  end

  // ==========================================================
  // Gate input synchroniser
  logic [3:0] gate_s1_q;
  logic [3:0] gate_s2_q;
  logic [3:0] gate_s3_q;
  logic [3:0] gate_q;
  logic [3:0] gate_agree;

  // Three-stage capture of the gate outputs
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      gate_s1_q <= 4'h0;
      gate_s2_q <= 4'h0;
      gate_s3_q <= 4'h0;
    end else begin
      gate_s1_q <= gate_in;
      gate_s2_q <= gate_s1_q;
      gate_s3_q <= gate_s2_q;
    end
  end

  assign gate_agree = ~(gate_s2_q ^ gate_s3_q);

  // Accept a bit only once stages two and three agree
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      gate_q <= 4'h0;
    end else begin
      gate_q <= (gate_s3_q & gate_agree) | (gate_q & ~gate_agree);
    end
  end

  // ==========================================================
  // Register decode
  logic wr_ctrl;
  logic wr_pol;
  logic wr_status;
  logic wr_mask;

  assign wr_ctrl = bus_req.wr && (bus_req.addr == OFF_CELL_CONTROL);
  assign wr_pol = bus_req.wr && (bus_req.addr == OFF_SIGNAL_POLARITY);
  assign wr_status = bus_req.wr && (bus_req.addr == OFF_IRQ_STATUS);
  assign wr_mask = bus_req.wr && (bus_req.addr == OFF_IRQ_MASK);

  // ==========================================================
  // Cell control register
  lcc_ctrl_t ctrl_q;

  // Cleared by the general reset only, not by power-on; status bit is never stored
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ctrl_q <= lcc_ctrl_t'(RST_CELL_CONTROL); // [R5]
    end else if (wr_ctrl) begin
      ctrl_q <= lcc_ctrl_t'(bus_req.wdata & WR_MASK_CELL_CONTROL);
    end
  end

  // ==========================================================
  // Signal polarity register
  lcc_pol_t pol_q;

  // Only power-on clears it, so a general reset keeps it
  always_ff @(posedge clk or negedge por_n_q) begin
    if (!por_n_q) begin
      pol_q <= lcc_pol_t'(RST_SIGNAL_POLARITY);
    end else if (wr_pol) begin
      pol_q <= lcc_pol_t'(bus_req.wdata & WR_MASK_SIGNAL_POLARITY); // [R5]
    end
  end

  // ==========================================================
  // Gate polarity and logic function
  logic [3:0] gate_eff;
  logic fn_out;
  logic final_out;

  // Per-gate optional inversion
  assign gate_eff = gate_q ^ {pol_q.gate4_invert, pol_q.gate3_invert,
                              pol_q.gate2_invert, pol_q.gate1_invert}; // [R3]

  lcc_logic_fn u_fn (
    .clk(clk),
    .rst_n(rst_n_q),
    .run(ctrl_q.cell_enable), // [R8]
    .function_select(ctrl_q.function_select), // [R1]
    .gate(gate_eff),
    .fn_out(fn_out)
  );

  // Output polarity stage
  assign final_out = fn_out ^ pol_q.output_invert; // [R2]

  // ==========================================================
  // Output and edge detection
  logic out_q;
  logic pin_q;
  logic rise_evt;
  logic fall_evt;
  logic edge_set;

  // Registered cell output, also the edge reference
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      out_q <= 1'b0;
    end else begin
      out_q <= final_out;
    end
  end

  // Pin data, registered, so it goes low one cycle after the pin stops being driven
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pin_q <= 1'b0;
    end else begin
      pin_q <= final_out & ctrl_q.pin_output_enable; // [R8]
    end
  end

  // Edges of the post-inversion output, so invert changes count too
  assign rise_evt = final_out & ~out_q; // [R6]
  assign fall_evt = ~final_out & out_q; // [R6]
  assign edge_set = (rise_evt & ctrl_q.rise_irq_enable) |
                    (fall_evt & ctrl_q.fall_irq_enable); // [R4]

  // ==========================================================
  // Interrupt status and mask
  logic status_q;
  logic mask_q;

  // Sticky flag, write one to clear, set wins
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      status_q <= RST_IRQ_STATUS[0];
    end else begin
      status_q <= (status_q & ~(wr_status & bus_req.wdata[0])) | edge_set; // [R7]
    end
  end

  // Interrupt mask
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      mask_q <= RST_IRQ_MASK[0];
    end else if (wr_mask) begin
      mask_q <= bus_req.wdata[0];
    end
  end

  // ==========================================================
  // Read data, valid only in the cycle after the strobe
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rd_mux;
  lcc_ctrl_t ctrl_view;

  // Live output status replaces the stored bit
  always_comb begin
    ctrl_view = ctrl_q;
    ctrl_view.cell_output_status = final_out; // [R2]
    case (bus_req.addr)
      OFF_CELL_CONTROL: rd_mux = ctrl_view;
      OFF_SIGNAL_POLARITY: rd_mux = pol_q;
      OFF_IRQ_STATUS: rd_mux = {7'h00, status_q};
      OFF_IRQ_MASK: rd_mux = {7'h00, mask_q};
      default: rd_mux = 8'h00;
    endcase
  end

  // Read data register
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= bus_req.rd ? rd_mux : 8'h00;
    end
  end

  // ==========================================================
  // Outputs
  assign rdata = rdata_q;
  assign cell_out = out_q;
  assign pin_out = pin_q;
  assign pin_oe_n = ~ctrl_q.pin_output_enable; // [R8]
  assign irq = status_q & mask_q;

endmodule
`default_nettype wire

// ===== sim/lcc_checker.sv
`default_nettype none
// ==========================================================
// Port-level checks of the logic cell
module lcc_checker (
  input wire logic clk,
  input wire logic rstn,
  input wire logic por_n,
  input wire lcc_pkg::lcc_bus_req_t bus_req,
  input wire logic [lcc_pkg::DATA_W-1:0] rdata,
  input wire logic [3:0] gate_in,
  input wire logic cell_out,
  input wire logic pin_out,
  input wire logic pin_oe_n,
  input wire logic irq
);
  import lcc_pkg::*;
  logic ctl_wr, ctl_rd, pol_rd, msk_off, st_clr, irq_wr;
  // Decoded bus cycles
  assign ctl_wr = bus_req.wr && bus_req.addr == OFF_CELL_CONTROL;
  assign ctl_rd = bus_req.rd && bus_req.addr == OFF_CELL_CONTROL;
  assign pol_rd = bus_req.rd && bus_req.addr == OFF_SIGNAL_POLARITY;
  assign msk_off = bus_req.wr && bus_req.addr == OFF_IRQ_MASK && !bus_req.wdata[0];
  assign st_clr = bus_req.wr && bus_req.addr == OFF_IRQ_STATUS && bus_req.wdata[0];
  assign irq_wr = bus_req.wr && bus_req.addr[3:1] == 3'h1;
  logic rise_en_q, fall_en_q, mask_h_q;
  // Shadow copies of the edge enables and the interrupt mask
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rise_en_q <= 1'b0;
      fall_en_q <= 1'b0;
      mask_h_q <= 1'b0;
    end else begin
      if (ctl_wr) begin
        rise_en_q <= bus_req.wdata[4];
        fall_en_q <= bus_req.wdata[3];
      end
      if (bus_req.wr && bus_req.addr == OFF_IRQ_MASK) begin
        mask_h_q <= bus_req.wdata[0];
      end
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // ==========================================================
  // Assertions
  chk_oe_write: assert property (ctl_wr |=> pin_oe_n == !$past(bus_req.wdata[6]))
    else $error("pin enable does not follow write");
  chk_oe_hold: assert property (!ctl_wr |=> $stable(pin_oe_n))
    else $error("pin enable moved without write");
  chk_pin_off: assert property (pin_oe_n |=> !pin_out)
    else $error("pin driven while disabled");
  chk_pin_follow: assert property (!$past(pin_oe_n) |-> pin_out == cell_out)
    else $error("pin differs from cell output");
  chk_status_rd: assert property (ctl_rd |=> rdata[5] == cell_out)
    else $error("status bit differs from output");
  chk_pol_rsvd: assert property (pol_rd |=> rdata[6:4] == 3'h0)
    else $error("unused polarity bits not zero");
  chk_irq_mask: assert property (msk_off |=> !irq)
    else $error("masked interrupt still high");
  chk_irq_clear: assert property (st_clr ##1 $stable(cell_out) |-> !irq)
    else $error("flag not cleared");
  chk_irq_hold: assert property (irq && !irq_wr |=> irq)
    else $error("interrupt dropped by itself");
  chk_irq_rise: assert property ($rose(cell_out) && $past(rise_en_q) && mask_h_q |-> irq)
    else $error("enabled rising edge gave no interrupt");
  chk_irq_fall: assert property ($fell(cell_out) && $past(fall_en_q) && mask_h_q |-> irq)
    else $error("enabled falling edge gave no interrupt");
  // Main scenarios
  cov_irq: cover property (irq);
  cov_rise: cover property ($rose(cell_out));
  cov_pin: cover property (!pin_oe_n && pin_out);
endmodule
bind lcc_top lcc_checker u_chk (.clk(clk), .rstn(rstn), .por_n(por_n), .bus_req(bus_req),
  .rdata(rdata), .gate_in(gate_in), .cell_out(cell_out), .pin_out(pin_out),
  .pin_oe_n(pin_oe_n), .irq(irq));
`default_nettype wire

// ===== sim/tb.sv
`default_nettype none
// ==========================================================
// Self-checking bench of the logic cell
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import lcc_pkg::*;
  logic clk = 0, rstn = 0, por_n = 0;
  logic cell_out, pin_out, pin_oe_n, irq;
  lcc_bus_req_t bus_req = '0;
  logic [DATA_W-1:0] rdata;
  logic [3:0] gate_in = 4'h0, e, f, g;
  logic [7:0] p;
  int miscompares = 0, n_compared = 0;
  // Rows: expected output, function, gates, polarity
  logic [19:0] rows [21] = '{20'h10300, 20'h00500, 20'h1050A, 20'h11100, 20'h01500,
    20'h12F00, 20'h02F80, 20'h12708, 20'h13100, 20'h13000, 20'h03400, 20'h14800,
    20'h04400, 20'h05400, 20'h05A00, 20'h15B00, 20'h06400, 20'h06200, 20'h16300,
    20'h17200, 20'h07500};
  lcc_top uut (.clk(clk), .rstn(rstn), .por_n(por_n), .bus_req(bus_req), .rdata(rdata),
    .gate_in(gate_in), .cell_out(cell_out), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .irq(irq));
  always #20 clk = ~clk;
  // Watchdog against a hang
  initial begin
    repeat (3000) @(posedge clk);
    miscompares++;
    summarize();
  end
  // ==========================================================
  // Tasks
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(logic [7:0] got, logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(logic [3:0] a, logic [7:0] d);
    @(posedge clk) bus_req <= {a, d, 2'b10};
    @(posedge clk) bus_req <= '0;
  endtask
  task automatic rd(logic [3:0] a, logic [7:0] x);
    @(posedge clk) bus_req <= {a, 8'h00, 2'b01};
    @(posedge clk) bus_req <= '0;
    #1 chk(rdata, x);
  endtask
  task automatic settle();
    repeat (8) @(posedge clk);
    #1;
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    por_n <= 1'b1;
    settle();
    for (int a = 0; a < 4; a++) begin
      rd(4'(a), 8'h00);
    end
    wr(4'hF, 8'hFF);
    rd(4'hF, 8'h00);
    chk({7'h0, pin_oe_n}, 8'h01);
    $display("reset test done");
    foreach (rows[i]) begin
      {e, f, g, p} = rows[i];
      wr(OFF_CELL_CONTROL, {5'h10, f[2:0]});
      wr(OFF_SIGNAL_POLARITY, p);
      @(posedge clk) gate_in <= g;
      settle();
      chk({7'h0, cell_out}, {7'h0, e[0]});
      rd(OFF_CELL_CONTROL, {2'b10, e[0], 2'b00, f[2:0]});
    end
    $display("function table done");
    // Writable bits, disabled cell, pin enable
    wr(OFF_SIGNAL_POLARITY, 8'hFF);
    rd(OFF_SIGNAL_POLARITY, 8'h8F);
    wr(OFF_SIGNAL_POLARITY, 8'h80);
    wr(OFF_CELL_CONTROL, 8'h42);
    @(posedge clk) gate_in <= 4'hF;
    settle();
    rd(OFF_CELL_CONTROL, 8'h62);
    chk({6'h0, pin_oe_n, pin_out}, 8'h01);
    // General reset keeps polarity
    @(posedge clk) rstn <= 1'b0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    settle();
    rd(OFF_CELL_CONTROL, 8'h20);
    rd(OFF_SIGNAL_POLARITY, 8'h80);
    rd(OFF_IRQ_STATUS, 8'h00);
    $display("control test done");
    // Edge interrupts
    wr(OFF_IRQ_MASK, 8'h01);
    wr(OFF_CELL_CONTROL, 8'h92);
    settle();
    rd(OFF_IRQ_STATUS, 8'h00);
    wr(OFF_SIGNAL_POLARITY, 8'h00);
    rd(OFF_IRQ_STATUS, 8'h01);
    chk({7'h0, irq}, 8'h01);
    wr(OFF_IRQ_MASK, 8'h00);
    #1 chk({7'h0, irq}, 8'h00);
    wr(OFF_IRQ_MASK, 8'h01);
    wr(OFF_IRQ_STATUS, 8'h01);
    rd(OFF_IRQ_STATUS, 8'h00);
    wr(OFF_CELL_CONTROL, 8'h8A);
    @(posedge clk) bus_req <= {OFF_SIGNAL_POLARITY, 8'h80, 2'b10};
    @(posedge clk) bus_req <= {OFF_IRQ_STATUS, 8'h01, 2'b10};
    @(posedge clk) bus_req <= '0;
    rd(OFF_IRQ_STATUS, 8'h01);
    wr(OFF_IRQ_STATUS, 8'h01);
    rd(OFF_IRQ_STATUS, 8'h00);
    chk({7'h0, irq}, 8'h00);
    $display("interrupt test done");
    summarize();
  end
endmodule
`default_nettype wire
